// file: hdl/rsv_defines.vh
`ifndef RSV_DEFINES_VH
`define RSV_DEFINES_VH
// Notes on behaviour
// - reset event: output low after filter, held while present, plus delay
// - power-up holds output low until regulator good and delay elapsed
// - watchdog failure asserts the reset output like an undervoltage
// - undervoltage level selectable by software, lowest level after reset
// - pull-down only while regulator at least 1V and battery above por
// - mode value 11 in normal or stop: soft reset to init, defaults
// - soft reset command outside normal or stop is ignored
// - config bit: soft reset pulses the output (default) or not
// - type bit selects time-out (default) or window watchdog
// - watchdog type and timing writable only in normal mode
// - init starts long window after release; stop keeps config or off
// - watchdog off in sleep and restart; normal restarts long window
// - new watchdog setting restarts the timer immediately
// - trigger is a valid watchdog write, acted on at chip select rise
// - long open window of 200 ms accepts any valid trigger
// - seven periods 10 to 1000 ms, shared by both types
// - watchdog reset enters restart or fail-safe, updates fail count
// - after watchdog reset release: long window and normal mode
// - development mode disables watchdog resets
// - closed-window trigger or expiry increments two-bit fail count
// - count saturates at 01 for config 2, at 10 otherwise
// - count clears on good trigger, stop disable, sleep, fail-safe; the code does not clear it in fail-safe
// - window type: closed 60 percent after trigger, then open window
// - time-out type: trigger restarts full period, expiry resets
// - watchdog data needs even parity, else ignored and flag set
`define RSV_CLK_MHZ 100
`define RSV_TICK_US 1000
`define RSV_TICK_CYC (`RSV_TICK_US * `RSV_CLK_MHZ)
`define RSV_FILT_US 10
`define RSV_FILT_CYC (`RSV_FILT_US * `RSV_CLK_MHZ)
`define RSV_RD_MS 10
`define RSV_LW_MS 200
`define RSV_CLOSED_PCT 8'h3C
`define RSV_OPEN_END_PCT 8'h8C
`define RSV_SPI_BITS 16
`define RSV_SPI_WR_BIT 15
`define RSV_ADR_MODE 7'h01
`define RSV_ADR_WD_CTRL 7'h03
`define RSV_WINDOW_TYPE_SELECT_BIT 4
`define RSV_WD_PER_RST 3'h1
`define RSV_CMD_NORMAL 2'h0
`define RSV_CMD_SLEEP 2'h1
`define RSV_CMD_STOP 2'h2
`define RSV_CMD_SOFT 2'h3
`define RSV_M_INIT 3'h0
`define RSV_M_NORMAL 3'h1
`define RSV_M_STOP 3'h2
`define RSV_M_SLEEP 3'h3
`define RSV_M_RESTART 3'h4
`define RSV_M_FAILSAFE 3'h5
`define RSV_WB_CFG 8'h00
`define RSV_WB_STAT 8'h04
`define RSV_WB_WD 8'h08
`define RSV_WB_CLR 8'h0C
`define RSV_CFG_RST 8'h14
`define RSV_CFG_SOFT_BIT 2
`define RSV_CFG_FS_BIT 3
`define RSV_CFG_STOPOFF_BIT 7
`endif

// file: hdl/rsv_supervisor.v
// The implementer's own choices: register access over Wishbone and the register addresses.
`include "rsv_defines.vh"

module rsv_supervisor #(
  parameter TICK_CYC = `RSV_TICK_CYC,
  parameter FILT_CYC = `RSV_FILT_CYC,
  parameter RD_MS = `RSV_RD_MS,
  parameter LW_MS = `RSV_LW_MS
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_spi_cs_n,
  input wire i_spi_clk,
  input wire i_spi_mosi,
  input wire i_vcc1_uv,
  input wire i_vcc1_ge_1v,
  input wire i_vs_above_por,
  input wire i_dev_mode,
  input wire i_wake,
  output reg o_reset_out_n_o,
  output reg o_reset_out_n_oe,
  output reg [1:0] o_uv_level_sel,
  output reg [2:0] o_mode
);

  // ms limit for a period setting scaled by a percentage
  function [10:0] per_ms;
    input [2:0] sel;
    input [7:0] pct;
    reg [31:0] p;
    begin
      case (sel)
        3'h2: p = 32'd20;
        3'h3: p = 32'd50;
        3'h4: p = 32'd100;
        3'h5: p = 32'd200;
        3'h6: p = 32'd500;
        3'h7: p = 32'd1000;
        default: p = 32'd10;
      endcase
      p = (p * {24'h0, pct}) / 32'd100;
      per_ms = p[10:0];
    end
  endfunction

  // input synchronisers: cs_n, sclk, mosi, uv, 1v, por, dev, wake
  // reset values match the idle select and clock, so no false edge
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  reg [1:0] prev_q;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= 8'h01;
      s2_q <= 8'h01;
      prev_q <= 2'h1;
    end else begin
      s1_q <= {i_wake, i_dev_mode, i_vs_above_por, i_vcc1_ge_1v,
               i_vcc1_uv, i_spi_mosi, i_spi_clk, i_spi_cs_n};
      s2_q <= s1_q;
      prev_q <= s2_q[1:0];
    end
  end

  wire cs_n = s2_q[0];
  wire sclk_rise = s2_q[1] & ~prev_q[1];
  wire cs_fall = ~s2_q[0] & prev_q[0];
  wire cs_rise = s2_q[0] & ~prev_q[0];
  wire mosi = s2_q[2];
  wire uv_s = s2_q[3];
  wire ge1v_s = s2_q[4];
  wire por_ok_s = s2_q[5];
  wire dev_s = s2_q[6];
  wire wake_s = s2_q[7];

  // millisecond time base
  // one shared tick: any ms count may run up to one tick short
  reg [16:0] pre_q;
  reg tick_q;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pre_q <= 17'h0;
      tick_q <= 1'b0;
    end else if (pre_q == TICK_CYC[16:0] - 17'h1) begin
      pre_q <= 17'h0;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 17'h1;
      tick_q <= 1'b0;
    end
  end

  // serial frame receiver, msb first, sampled on sclk rise
  // sclk must rest low at select edges or a bit is lost
  reg [15:0] shf_q;
  reg [4:0] bits_q;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      shf_q <= 16'h0;
      bits_q <= 5'h0;
    end else if (cs_fall) begin
      bits_q <= 5'h0;
    end else if (sclk_rise && !cs_n) begin
      shf_q <= {shf_q[14:0], mosi};
      if (bits_q != 5'h11) begin
        bits_q <= bits_q + 5'h1;
      end
    end
  end

  // a frame of any other length is dropped whole
  wire frame_ok = cs_rise && bits_q == `RSV_SPI_BITS;
  wire wr_frame = frame_ok & shf_q[`RSV_SPI_WR_BIT];
  wire wd_wr = wr_frame && shf_q[14:8] == `RSV_ADR_WD_CTRL;
  wire mode_wr = wr_frame && shf_q[14:8] == `RSV_ADR_MODE;
  wire par_ok = ~^shf_q[7:0];
  wire wd_wr_ok = wd_wr & par_ok;
  wire par_err = wd_wr & ~par_ok;
  wire [1:0] cmd = shf_q[1:0];

  // state
  reg [2:0] mode_q;
  reg [7:0] cfg_q;
  reg [2:0] wd_per_q;
  reg window_type_select_q;
  reg wd_on_q;
  reg lw_q;
  reg [10:0] wd_ms_q;
  reg [1:0] fail_q;
  reg spi_fail_q;
  reg uv_flt_q;
  reg [12:0] filt_q;
  reg ro_low_q;
  reg [10:0] dly_q;

  wire m_norm = mode_q == `RSV_M_NORMAL;
  wire m_stop = mode_q == `RSV_M_STOP;
  wire soft_exec = mode_wr && cmd == `RSV_CMD_SOFT &&
                   (m_norm || m_stop);
  wire soft_pulse = soft_exec & cfg_q[`RSV_CFG_SOFT_BIT];
  wire stop_off = m_stop & cfg_q[`RSV_CFG_STOPOFF_BIT];
  wire asleep = mode_q == `RSV_M_SLEEP ||
                mode_q == `RSV_M_FAILSAFE;
  wire wake_rst = asleep & wake_s;
  wire m_sleep = mode_q == `RSV_M_SLEEP;

  // watchdog limits
  wire [10:0] lim_closed = per_ms(wd_per_q, `RSV_CLOSED_PCT);
  wire [10:0] lim_end = window_type_select_q ? per_ms(wd_per_q, `RSV_OPEN_END_PCT) :
                        per_ms(wd_per_q, 8'h64);
  wire [10:0] lim = lw_q ? LW_MS[10:0] : lim_end;
  wire wd_live = wd_on_q & ~dev_s & ~ro_low_q;
  wire trig = wd_wr_ok & wd_live;
  wire bad_trig = trig & ~lw_q & window_type_select_q &
                  (wd_ms_q < lim_closed);
  wire good_trig = trig & ~bad_trig;
  wire expire = wd_live && wd_ms_q >= lim;
  wire trigger_failure_count = (expire | bad_trig) & ~soft_exec;
  wire cfg_wr = wd_wr_ok & m_norm;
  wire stop_on = wd_wr_ok & m_stop & ~wd_on_q;
  wire pulse_ev = trigger_failure_count | soft_pulse | wake_rst;
  wire ro_rel = ro_low_q && !uv_flt_q && dly_q >= RD_MS[10:0] &&
                !pulse_ev && mode_q != `RSV_M_FAILSAFE;

  // undervoltage filter
  // any clean sample restarts the filter
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      filt_q <= 13'h0;
      uv_flt_q <= 1'b1;
    end else if (!uv_s) begin
      filt_q <= 13'h0;
      uv_flt_q <= 1'b0;
    end else if (filt_q == FILT_CYC[12:0]) begin
      uv_flt_q <= 1'b1;
    end else begin
      filt_q <= filt_q + 13'h1;
    end
  end

  // reset output low phase and delay
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ro_low_q <= 1'b1;
      dly_q <= 11'h0;
    end else if (uv_flt_q || pulse_ev) begin
      ro_low_q <= 1'b1;
      dly_q <= 11'h0;
    end else if (ro_rel) begin
      ro_low_q <= 1'b0;
    end else if (ro_low_q && tick_q && dly_q != 11'h7FF) begin
      dly_q <= dly_q + 11'h1;
    end
  end

  // open-drain pin: only a pull-down, weak supply leaves it floating
  // both supply checks pass the syncs, so the pin lets go two cycles late
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reset_out_n_o <= 1'b0;
      o_reset_out_n_oe <= 1'b0;
    end else begin
      o_reset_out_n_o <= 1'b0;
      o_reset_out_n_oe <= ro_low_q & ge1v_s & por_ok_s;
    end
  end

  // operating mode
  // mode commands other than soft reset are dropped while the pin is held low
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_q <= `RSV_M_INIT;
    end else if (trigger_failure_count) begin
      mode_q <= cfg_q[`RSV_CFG_FS_BIT] ? `RSV_M_FAILSAFE :
                `RSV_M_RESTART;
    end else if (uv_flt_q && (m_norm || m_stop)) begin
      mode_q <= `RSV_M_RESTART;
    end else if (wake_rst) begin
      mode_q <= `RSV_M_RESTART;
    end else if (soft_exec) begin
      mode_q <= `RSV_M_INIT;
    end else if (ro_rel && mode_q == `RSV_M_RESTART) begin
      mode_q <= `RSV_M_NORMAL;
    end else if (mode_wr && !ro_low_q) begin
      case (mode_q)
        `RSV_M_INIT: begin
          if (cmd == `RSV_CMD_NORMAL) begin
            mode_q <= `RSV_M_NORMAL;
          end
        end
        `RSV_M_NORMAL: begin
          if (cmd == `RSV_CMD_SLEEP) begin
            mode_q <= `RSV_M_SLEEP;
          end else if (cmd == `RSV_CMD_STOP) begin
            mode_q <= `RSV_M_STOP;
          end
        end
        `RSV_M_STOP: begin
          if (cmd == `RSV_CMD_NORMAL) begin
            mode_q <= `RSV_M_NORMAL;
          end
        end
        default: begin
          mode_q <= mode_q;
        end
      endcase
    end
  end

  // watchdog timer
  // a normal-mode write is a new setting plus restart
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wd_on_q <= 1'b0;
      lw_q <= 1'b1;
      wd_ms_q <= 11'h0;
      wd_per_q <= `RSV_WD_PER_RST;
      window_type_select_q <= 1'b0;
    end else if (soft_exec) begin
      wd_on_q <= 1'b0;
      lw_q <= 1'b1;
      wd_ms_q <= 11'h0;
      wd_per_q <= `RSV_WD_PER_RST;
      window_type_select_q <= 1'b0;
    end else if (trigger_failure_count || ro_low_q || asleep ||
                 mode_q == `RSV_M_RESTART || stop_off) begin
      wd_on_q <= 1'b0;
      lw_q <= 1'b1;
      wd_ms_q <= 11'h0;
    end else if (!wd_on_q) begin
      // init and restart come through here once the pin is released
      if (mode_q == `RSV_M_INIT || m_norm || stop_on) begin
        wd_on_q <= 1'b1;
        lw_q <= 1'b1;
        wd_ms_q <= 11'h0;
      end
    end else if (cfg_wr) begin
      wd_per_q <= shf_q[2:0];
      window_type_select_q <= shf_q[`RSV_WINDOW_TYPE_SELECT_BIT];
      lw_q <= 1'b0;
      wd_ms_q <= 11'h0;
    end else if (good_trig) begin
      lw_q <= 1'b0;
      wd_ms_q <= 11'h0;
    end else if (mode_wr && m_stop && cmd == `RSV_CMD_NORMAL) begin
      lw_q <= 1'b1;
      wd_ms_q <= 11'h0;
    end else if (tick_q && !dev_s && wd_ms_q != 11'h7FF) begin
      // development mode freezes the count so leaving it cannot expire
      wd_ms_q <= wd_ms_q + 11'h1;
    end
  end

  // failure counter; the increment wins over a clear in the same cycle, except a soft reset, which suppresses the increment
  wire [1:0] fail_max = (cfg_q[6:4] == 3'h2) ? 2'h1 : 2'h2;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      fail_q <= 2'h0;
    end else if (trigger_failure_count) begin
      if (fail_q < fail_max) begin
        fail_q <= fail_q + 2'h1;
      end
    // fail-safe is only reached by a watchdog fault, so
    // of the two, sleep clears the count, never fail-safe
    end else if (good_trig || stop_off || m_sleep || soft_exec) begin
      fail_q <= 2'h0;
    end
  end

  // serial failure flag, set wins over software clear
  wire clr_hit = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack &
                 i_wb_sel[0] && i_wb_adr == `RSV_WB_CLR;
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      spi_fail_q <= 1'b0;
    end else if (par_err) begin
      spi_fail_q <= 1'b1;
    end else if (soft_exec || (clr_hit && i_wb_dat[0])) begin
      spi_fail_q <= 1'b0;
    end
  end

  // wishbone slave, answers one cycle after the strobe
  // unmapped addresses still ack and read zero
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  reg [31:0] rd_d;
  always @* begin
    case (i_wb_adr)
      `RSV_WB_CFG: rd_d = {24'h0, cfg_q};
      `RSV_WB_STAT: rd_d = {23'h0, ~ro_low_q, lw_q, wd_on_q,
                            spi_fail_q, fail_q, mode_q};
      `RSV_WB_WD: rd_d = {28'h0, window_type_select_q, wd_per_q};
      default: rd_d = 32'h0;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      cfg_q <= `RSV_CFG_RST;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= rd_d;
      end
      if (soft_exec) begin
        cfg_q <= `RSV_CFG_RST;
      end else if (wb_req && i_wb_we && i_wb_sel[0] &&
                   i_wb_adr == `RSV_WB_CFG) begin
        cfg_q <= i_wb_dat[7:0];
      end
    end
  end

  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_uv_level_sel <= 2'h0;
      o_mode <= `RSV_M_INIT;
    end else begin
      o_uv_level_sel <= cfg_q[1:0];
      o_mode <= mode_q;
    end
  end

endmodule

// file: verif/rsv_supervisor_chk.sv
module rsv_supervisor_chk #(
  parameter int TICK_CYC = 100,
  parameter int FILT_CYC = 10,
  parameter int RD_MS = 2
) (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_vcc1_uv,
  input wire i_vcc1_ge_1v,
  input wire i_vs_above_por,
  input wire i_wake,
  input wire o_wb_ack,
  input wire o_reset_out_n_oe,
  input wire [2:0] o_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  wire pwr = i_vcc1_ge_1v && i_vs_above_por;
  int hi_q;
  int lo_q;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  // run lengths of undervoltage; margins cover the input syncs
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      hi_q <= 0;
      lo_q <= 0;
    end else begin
      hi_q <= i_vcc1_uv ? hi_q + 1 : 0;
      lo_q <= i_vcc1_uv ? 0 : lo_q + 1;
    end
  end
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_restart_done;
    $fell(o_reset_out_n_oe) && pwr && $past(o_mode) == 3'h4;
  endsequence
  property p_ack;
    s_req |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack width");
  property p_pin_pwr;
    (!pwr) [*4] |=> !o_reset_out_n_oe;
  endproperty
  a_pin_pwr: assert property (p_pin_pwr) else $error("pin driven");
  property p_filt;
    hi_q == FILT_CYC + 6 && pwr |-> o_reset_out_n_oe;
  endproperty
  a_filt: assert property (p_filt) else $error("pin not low");
  property p_hold;
    $fell(o_reset_out_n_oe) && pwr |-> lo_q >= (RD_MS - 1) * TICK_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_init;
    $changed(o_mode) && o_mode == 3'h0
      |-> $past(o_mode) inside {3'h1, 3'h2};
  endproperty
  a_init: assert property (p_init) else $error("bad init entry");
  property p_sleep;
    (o_mode == 3'h3 && !i_wake) [*4] |=> o_mode == 3'h3;
  endproperty
  a_sleep: assert property (p_sleep) else $error("left sleep");
  property p_rst_mode;
    $changed(o_mode) && o_mode == 3'h4 && pwr |-> ##[0:4] o_reset_out_n_oe;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("no pin");
  property p_rst_exit;
    s_restart_done |-> ##[0:8] o_mode == 3'h1;
  endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("stuck");
endmodule

bind rsv_supervisor rsv_supervisor_chk #(
  .TICK_CYC(TICK_CYC),
  .FILT_CYC(FILT_CYC),
  .RD_MS(RD_MS)
) rsv_supervisor_chk_inst (
  .i_sys_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_vcc1_uv, .i_vcc1_ge_1v,
  .i_vs_above_por, .i_wake, .o_wb_ack, .o_reset_out_n_oe, .o_mode
);

// file: verif/rsv_spi_host.sv
module rsv_spi_host (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_reset_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b1;
  end
  // sclk parks low so no stray edge lands at a select edge
  task automatic send(input logic [15:0] w);
    wait (i_reset_out_n === 1'b1);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    #400;
  endtask
  // spare bit 3 balances the parity
  task automatic wd(input logic [7:0] d, input logic bad);
    d[3] = ^{d[7:4], d[2:0]} ^ bad;
    send({8'h83, d});
  endtask
endmodule

// file: verif/rsv_supervisor_bench.sv
module rsv_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
  logic uv = 1'b1, ge1v = 1'b1, dev = 1'b0, wake = 1'b0, por = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q;
  wire [31:0] rdat;
  wire [2:0] mode;
  wire [1:0] uvsel;
  wire ack, pin_o, oe, cs_n, sclk, mosi;
  // external pull-up once the pin is let go
  wire pin = oe ? pin_o : 1'b1;
  int err_count = 0, n_tests = 0, cycles = 0;
  always #5 clk = ~clk;
  rsv_supervisor #(.TICK_CYC(100), .FILT_CYC(10), .RD_MS(2), .LW_MS(20))
  rsv_supervisor_inst (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_spi_cs_n(cs_n),
    .i_spi_clk(sclk), .i_spi_mosi(mosi), .i_vcc1_uv(uv),
    .i_vcc1_ge_1v(ge1v), .i_vs_above_por(por), .i_dev_mode(dev),
    .i_wake(wake), .o_reset_out_n_o(pin_o), .o_reset_out_n_oe(oe),
    .o_uv_level_sel(uvsel), .o_mode(mode));
  rsv_spi_host rsv_spi_host_inst (.o_cs_n(cs_n), .o_sclk(sclk),
    .o_mosi(mosi), .i_reset_out_n(pin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wpin(input logic v, input int n);
    for (int i = 0; i < n && oe !== v; i++) @(posedge clk);
    chk(oe, v);
  endtask
  task automatic sp(input logic [15:0] w);
    rsv_spi_host_inst.send(w);
    @(posedge clk);
  endtask
  task automatic wdw(input logic [7:0] d, input logic bad);
    rsv_spi_host_inst.wd(d, bad);
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wpin(1'b1, 20);
    chk(pin, 1'b0);
    rc(8'h00, 32'h14);
    rc(8'h08, 32'h01);
    rc(8'h10, 32'h00);
    chk(uvsel, 2'h0);
    wb(1'b1, 8'h00, 32'h16);
    @(posedge clk);
    chk(uvsel, 2'h2);
    uv <= 1'b0;
    wpin(1'b0, 500);
    sp(16'h8103);
    chk(mode, 3'h0);
    chk(oe, 1'b0);
    sp(16'h8100);
    chk(mode, 3'h1);
    wdw(8'h12, 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[5], 1'b1);
    rc(8'h08, 32'h01);
    wb(1'b1, 8'h0C, 32'h1);
    wdw(8'h12, 1'b0);
    rc(8'h08, 32'h0A);
    wpin(1'b1, 3500);
    chk(mode, 3'h4);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[4:3], 2'h1);
    wpin(1'b0, 500);
    repeat (10) @(posedge clk);
    chk(mode, 3'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[7], 1'b1);
    // fail config 2 first, while the count already reads 01
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 8'h00, k ? 32'h16 : 32'h26);
      wpin(1'b1, 3000);
      wpin(1'b0, 500);
      wb(1'b0, 8'h04, 32'h0);
      chk(q[4:3], k ? 2'h2 : 2'h1);
    end
    // window type, 10 ms: second trigger lands in the closed part
    wdw(8'h11, 1'b0);
    wdw(8'h11, 1'b0);
    wpin(1'b1, 50);
    chk(mode, 3'h4);
    wpin(1'b0, 500);
    for (int k = 0; k < 4; k++) begin
      wdw(8'h01, 1'b0);
      repeat (400) @(posedge clk);
    end
    chk(oe, 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[4:3], 2'h0);
    dev <= 1'b1;
    repeat (1500) @(posedge clk);
    chk(oe, 1'b0);
    wdw(8'h01, 1'b0);
    dev <= 1'b0;
    sp(16'h8103);
    wpin(1'b1, 20);
    chk(mode, 3'h0);
    rc(8'h00, 32'h14);
    rc(8'h08, 32'h01);
    wpin(1'b0, 500);
    sp(16'h8100);
    wb(1'b1, 8'h00, 32'h10);
    sp(16'h8103);
    chk(mode, 3'h0);
    repeat (20) @(posedge clk);
    chk(oe, 1'b0);
    sp(16'h8100);
    sp(16'h8101);
    repeat (2500) @(posedge clk);
    chk(mode, 3'h3);
    chk(oe, 1'b0);
    wake <= 1'b1;
    wpin(1'b1, 50);
    wake <= 1'b0;
    wpin(1'b0, 500);
    repeat (10) @(posedge clk);
    chk(mode, 3'h1);
    uv <= 1'b1;
    repeat (5) @(posedge clk);
    uv <= 1'b0;
    repeat (20) @(posedge clk);
    chk(oe, 1'b0);
    uv <= 1'b1;
    wpin(1'b1, 30);
    ge1v <= 1'b0;
    repeat (8) @(posedge clk);
    chk(oe, 1'b0);
    ge1v <= 1'b1;
    por <= 1'b0;
    repeat (8) @(posedge clk);
    chk(oe, 1'b0);
    por <= 1'b1;
    uv <= 1'b0;
    repeat (400) @(posedge clk);
    chk(mode, 3'h1);
    // stop keeps the 10 ms time-out setting and still runs
    sp(16'h8102);
    chk(mode, 3'h2);
    wdw(8'h17, 1'b0);
    rc(8'h08, 32'h01);
    wpin(1'b1, 1500);
    chk(mode, 3'h4);
    wpin(1'b0, 500);
    report_and_stop();
  end
endmodule
